/* File: src/sepv_regs.sv */
// egress pacing and default tag register bank on an APB slave port
// assumes a single 100 MHz clock, synchronous reset, APB master on the same clock
//
// What this block does
// - pacing time per byte is (value+1) x 20 ns
// - port 1 queue 0 low, queue 1 high
// - port 1 queue 2 low, queue 3 high
// - port 2 queue 0 low, queue 1 high
// - port 2 queue 2 low, queue 3 high
// - pacing only acts with the global enable
// - per-port 3-bit default priority, resets to zero
// - per-port 12-bit default VLAN id, resets to one
// - three default tag registers, consecutive numbers
// - two-bit egress type selects tag handling
module sepv_regs #(
	parameter int UNIT_CYC = sepv_pkg::RATE_UNIT_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire sepv_pkg::sepv_apb_req_t i_apb,
	input wire logic [sepv_pkg::NUM_QUEUES-1:0] i_byte_sent,
	output sepv_pkg::sepv_apb_rsp_t o_apb,
	output logic [sepv_pkg::NUM_QUEUES-1:0][sepv_pkg::RATE_W-1:0] o_queue_rate,
	output logic [sepv_pkg::NUM_QUEUES-1:0] o_queue_ready,
	output logic o_pace_enable,
	output sepv_pkg::sepv_port_tag_t [sepv_pkg::NUM_PORTS-1:0] o_port_tag,
	output sepv_pkg::sepv_tag_action_t [sepv_pkg::NUM_PORTS-1:0] o_port_action
);

	// ----------------------------------------------------------------
	// slot tables
	// ----------------------------------------------------------------
	// slot order: four rate words, three tag words, control, status
	localparam logic [13:0] SLOT_IDX [sepv_pkg::NUM_SLOTS] = '{
		sepv_pkg::IDX_P1_Q01_RATE,
		sepv_pkg::IDX_P1_Q23_RATE,
		sepv_pkg::IDX_P2_Q01_RATE,
		sepv_pkg::IDX_P2_Q23_RATE,
		sepv_pkg::IDX_P0_TAG,
		sepv_pkg::IDX_P1_TAG,
		sepv_pkg::IDX_P2_TAG,
		sepv_pkg::IDX_EGRESS_CTRL,
		sepv_pkg::IDX_PACE_STATUS
	};
	// bits that exist in each slot, everything else is reserved
	localparam logic [31:0] SLOT_MASK [sepv_pkg::NUM_SLOTS] = '{
		sepv_pkg::RATE_MASK,
		sepv_pkg::RATE_MASK,
		sepv_pkg::RATE_MASK,
		sepv_pkg::RATE_MASK,
		sepv_pkg::TAG_MASK,
		sepv_pkg::TAG_MASK,
		sepv_pkg::TAG_MASK,
		sepv_pkg::CTRL_MASK,
		sepv_pkg::STATUS_MASK
	};
	localparam logic [31:0] SLOT_RST [sepv_pkg::NUM_STORE] = '{
		sepv_pkg::RATE_RST,
		sepv_pkg::RATE_RST,
		sepv_pkg::RATE_RST,
		sepv_pkg::RATE_RST,
		sepv_pkg::TAG_RST,
		sepv_pkg::TAG_RST,
		sepv_pkg::TAG_RST,
		sepv_pkg::CTRL_RST
	};
	localparam logic [3:0] SLOT_NONE = 4'h9; // unmapped address
	localparam logic [3:0] SLOT_TAG0 = 4'h4;
	localparam logic [3:0] SLOT_CTRL = 4'h7;
	localparam logic [3:0] SLOT_STATUS = 4'h8;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// address to slot; misaligned or unknown addresses give SLOT_NONE
	function automatic logic [3:0] sepv_slot(input logic [15:0] addr);
		logic [3:0] slot;
		slot = SLOT_NONE;
		for (int i = 0; i < sepv_pkg::NUM_SLOTS; i++)
		begin
			if (addr[1:0] == 2'h0 && addr[15:2] == SLOT_IDX[i])
			begin
				slot = 4'(i);
			end
		end
		return slot;
	endfunction : sepv_slot

	// byte-lane merge limited to implemented bits
	function automatic logic [31:0] sepv_merge(input logic [31:0] old, input logic [31:0] wdata,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old & ~lanes) | (wdata & lanes);
	endfunction : sepv_merge

	// egress type to tag handling
	function automatic sepv_pkg::sepv_tag_action_t sepv_decode(input sepv_pkg::sepv_egress_type_t t);
		sepv_pkg::sepv_tag_action_t a;
		a.strip_normal = (t == sepv_pkg::SEPV_EGR_STRIP);
		a.strip_special = (t == sepv_pkg::SEPV_EGR_PASS) || (t == sepv_pkg::SEPV_EGR_STRIP);
		a.retag = (t == sepv_pkg::SEPV_EGR_HYBRID);
		a.add_src_tag = (t == sepv_pkg::SEPV_EGR_SRC_TAG);
		return a;
	endfunction : sepv_decode

	// ----------------------------------------------------------------
	// storage and bus decode
	// ----------------------------------------------------------------
	logic [31:0] regs_reg [sepv_pkg::NUM_STORE]; // writable words
	logic [3:0] slot; // slot of the current address
	logic access; // access phase while no answer is out yet
	logic commit; // edge at which the master samples pready
	logic [31:0] rd_word; // masked read value
	logic [sepv_pkg::NUM_QUEUES-1:0] pacer_ready; // live pacer state

	always_comb
	begin
		slot = sepv_slot(i_apb.paddr);
	end

	assign access = i_apb.psel && i_apb.penable && !o_apb.pready;
	assign commit = i_apb.psel && i_apb.penable && o_apb.pready;

	// read mux: reserved bits forced low
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (slot == SLOT_STATUS)
		begin
			rd_word = 32'(pacer_ready) & sepv_pkg::STATUS_MASK;
		end
		else if (slot < SLOT_STATUS)
		begin
			rd_word = regs_reg[slot[2:0]] & SLOT_MASK[slot];
		end
	end

	// ----------------------------------------------------------------
	// APB answer: one wait state so that every output is a flop
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_apb <= '0;
		end
		else if (access)
		begin
			// answer one cycle into the access phase
			o_apb.pready <= 1'b1;
			o_apb.prdata <= i_apb.pwrite ? 32'h0000_0000 : rd_word;
			o_apb.pslverr <= (slot == SLOT_NONE);
		end
		else
		begin
			// answer stands one cycle only
			o_apb.pready <= 1'b0;
			o_apb.prdata <= 32'h0000_0000;
			o_apb.pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register writes, taken at the edge where pready is sampled
	// ----------------------------------------------------------------
	// status is read only, so a write to it is quietly dropped
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < sepv_pkg::NUM_STORE; i++)
			begin
				regs_reg[i] <= SLOT_RST[i];
			end
		end
		else if (commit && i_apb.pwrite && slot < SLOT_STATUS)
		begin
			regs_reg[slot[2:0]] <= sepv_merge(regs_reg[slot[2:0]], i_apb.pwdata, i_apb.pstrb,
				SLOT_MASK[slot]);
		end
	end

	// ----------------------------------------------------------------
	// pacing fields and pacers, queue q of port p is index 4(p-1)+q
	// ----------------------------------------------------------------
	assign o_pace_enable = regs_reg[SLOT_CTRL[2:0]][sepv_pkg::PACE_EN_BIT];

	generate
		for (genvar q = 0; q < sepv_pkg::NUM_QUEUES; q++)
		begin : g_queue
			// even queues in the low field, odd ones in the high field
			localparam int LSB = (q % 2 == 0) ? sepv_pkg::RATE_LO_LSB : sepv_pkg::RATE_HI_LSB;
			assign o_queue_rate[q] = regs_reg[q / 2][LSB +: sepv_pkg::RATE_W];

			sepv_byte_pacer #(
				.RATE_W(sepv_pkg::RATE_W),
				.UNIT_CYC(UNIT_CYC)
			) u_pacer (
				.i_ref_clk(i_ref_clk),
				.i_srst(i_srst),
				.i_enable(o_pace_enable),
				.i_rate(o_queue_rate[q]),
				.i_byte_sent(i_byte_sent[q]),
				.o_byte_ready(pacer_ready[q])
			);
		end
	endgenerate

	assign o_queue_ready = pacer_ready;

	// ----------------------------------------------------------------
	// default tags and egress handling per port
	// ----------------------------------------------------------------
	generate
		for (genvar p = 0; p < sepv_pkg::NUM_PORTS; p++)
		begin : g_port
			// tag words sit at consecutive slots, one per port
			assign o_port_tag[p].prio =
				regs_reg[SLOT_TAG0[2:0] + 3'(p)][sepv_pkg::PRIO_LSB +: sepv_pkg::PRIO_W];
			assign o_port_tag[p].vid =
				regs_reg[SLOT_TAG0[2:0] + 3'(p)][sepv_pkg::VID_LSB +: sepv_pkg::VID_W];
			assign o_port_tag[p].egress_type = sepv_pkg::sepv_egress_type_t'(
				regs_reg[SLOT_CTRL[2:0]][p * sepv_pkg::TYPE_STRIDE +: sepv_pkg::TYPE_W]);

			// registered so the action flags are clean flops; they trail the type by one cycle
			always_ff @(posedge i_ref_clk)
			begin
				if (i_srst)
				begin
					o_port_action[p] <= sepv_decode(sepv_pkg::SEPV_EGR_PASS);
				end
				else
				begin
					o_port_action[p] <= sepv_decode(o_port_tag[p].egress_type);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_setup;
		i_apb.psel && !i_apb.penable;
	endsequence

	sequence s_wait_answer;
		(i_apb.psel && i_apb.penable && !o_apb.pready) ##1 (i_apb.psel && i_apb.penable && o_apb.pready);
	endsequence

	// a whole-word write landing in slot s, usable as an antecedent
	sequence p_full_write(logic [3:0] s);
		commit && i_apb.pwrite && i_apb.pstrb == 4'hf && slot == s;
	endsequence

	AST_ANSWER_TIMING: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_setup ##1 (i_apb.psel && i_apb.penable) |-> !o_apb.pready ##1 o_apb.pready)
		else $error("answer not one cycle into the access phase");

	AST_ANSWER_PULSE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_wait_answer |=> !o_apb.pready)
		else $error("pready held longer than one cycle");

	AST_P1_Q01: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(4'h0) |=> o_queue_rate[0] == $past(i_apb.pwdata[12:0])
		&& o_queue_rate[1] == $past(i_apb.pwdata[25:13]))
		else $error("port 1 queue 0/1 fields misplaced");

	AST_P1_Q23: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(4'h1) |=> o_queue_rate[2] == $past(i_apb.pwdata[12:0])
		&& o_queue_rate[3] == $past(i_apb.pwdata[25:13]))
		else $error("port 1 queue 2/3 fields misplaced");

	AST_P2_Q01: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(4'h2) |=> o_queue_rate[4] == $past(i_apb.pwdata[12:0])
		&& o_queue_rate[5] == $past(i_apb.pwdata[25:13]))
		else $error("port 2 queue 0/1 fields misplaced");

	AST_P2_Q23: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(4'h3) |=> o_queue_rate[6] == $past(i_apb.pwdata[12:0])
		&& o_queue_rate[7] == $past(i_apb.pwdata[25:13]))
		else $error("port 2 queue 2/3 fields misplaced");

	AST_TAG_RESET: assert property (@(posedge i_ref_clk)
		$past(i_srst) |-> o_port_tag[0].vid == 12'h001 && o_port_tag[2].vid == 12'h001)
		else $error("default vlan id not one after reset");

	AST_PRIO_RESET: assert property (@(posedge i_ref_clk)
		$past(i_srst) |-> o_port_tag[1].prio == 3'h0)
		else $error("default priority not zero after reset");

	AST_TAG_SEPARATE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(4'h5) |=> o_port_tag[1].vid == $past(i_apb.pwdata[11:0])
		&& $stable(o_port_tag[0]) && $stable(o_port_tag[2].vid))
		else $error("port 1 tag write leaked into another port");

	AST_RSVD_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		access && !i_apb.pwrite && slot == SLOT_TAG0 |=> o_apb.prdata[31:15] == 17'h00000)
		else $error("reserved tag bits read non-zero");

	AST_TYPE_DECODE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		##1 o_port_action[2].retag == ($past(o_port_tag[2].egress_type) == sepv_pkg::SEPV_EGR_HYBRID)
		&& o_port_action[2].strip_normal == ($past(o_port_tag[2].egress_type) == sepv_pkg::SEPV_EGR_STRIP))
		else $error("egress type decoded wrongly");

	AST_PACE_GATED: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!o_pace_enable |=> o_queue_ready == 8'hff)
		else $error("queue held back while pacing disabled");

	// refused accesses and idle answer fields; a leak here would let software see stale data
	AST_ERR_UNMAPPED: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		access && slot == SLOT_NONE |=> o_apb.pslverr && o_apb.prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	AST_STATUS_RO: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		commit && i_apb.pwrite && slot == SLOT_STATUS |=> $stable(o_queue_rate) && $stable(o_port_tag)
		&& $stable(o_pace_enable))
		else $error("write to status register changed a field");

	AST_RSVD_RATE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		access && !i_apb.pwrite && slot < SLOT_TAG0 |=> o_apb.prdata[31:26] == 6'h00)
		else $error("reserved pacing bits read non-zero");

	AST_PRIO_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(4'h6) |=> o_port_tag[2].prio == $past(i_apb.pwdata[14:12]))
		else $error("port 2 default priority misplaced");

	AST_VID_P0: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(4'h4) |=> o_port_tag[0].vid == $past(i_apb.pwdata[11:0]))
		else $error("port 0 default vlan id misplaced");

	AST_PACE_ENABLE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		p_full_write(SLOT_CTRL) |=> o_pace_enable == $past(i_apb.pwdata[sepv_pkg::PACE_EN_BIT]))
		else $error("pacing enable bit misplaced");

	AST_IDLE_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!o_apb.pready |-> o_apb.prdata == 32'h0000_0000 && !o_apb.pslverr)
		else $error("answer fields not zero between answers");

endmodule : sepv_regs

/* File: include/sepv_pkg.sv */
// shared constants and types of the egress pacing and default tag register bank
// assumes one 100 MHz system clock and an APB master with 32-bit data
package sepv_pkg;

	// ----------------------------------------------------------------
	// bus shape
	// ----------------------------------------------------------------
	localparam int APB_AW = 16; // byte address width, covers 4 x 1c1f
	localparam int APB_DW = 32; // data width

	// ----------------------------------------------------------------
	// register numbers, byte address is four times the number
	// ----------------------------------------------------------------
	localparam logic [13:0] IDX_P1_Q01_RATE = 14'h1c0f;
	localparam logic [13:0] IDX_P1_Q23_RATE = 14'h1c10;
	localparam logic [13:0] IDX_P2_Q01_RATE = 14'h1c11;
	localparam logic [13:0] IDX_P2_Q23_RATE = 14'h1c12;
	localparam logic [13:0] IDX_P0_TAG = 14'h1c13;
	localparam logic [13:0] IDX_P1_TAG = 14'h1c14;
	localparam logic [13:0] IDX_P2_TAG = 14'h1c15;
	localparam logic [13:0] IDX_EGRESS_CTRL = 14'h1c1e; // egress types and pacing enable
	localparam logic [13:0] IDX_PACE_STATUS = 14'h1c1f; // live per-queue ready flags
	localparam int NUM_STORE = 8; // writable slots
	localparam int NUM_SLOTS = 9; // all mapped slots, status last

	// ----------------------------------------------------------------
	// field positions and widths
	// ----------------------------------------------------------------
	localparam int RATE_W = 13;
	localparam int RATE_LO_LSB = 0;
	localparam int RATE_HI_LSB = 13;
	localparam int VID_W = 12;
	localparam int VID_LSB = 0;
	localparam int PRIO_W = 3;
	localparam int PRIO_LSB = 12;
	localparam int TYPE_W = 2;
	localparam int TYPE_STRIDE = 8; // port n type sits at bits 8n+1:8n
	localparam int PACE_EN_BIT = 24;
	localparam int NUM_PORTS = 3;
	localparam int NUM_QUEUES = 8; // four queues on each of ports 1 and 2

	// ----------------------------------------------------------------
	// writable and status masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RATE_MASK = 32'h03ff_ffff;
	localparam logic [31:0] TAG_MASK = 32'h0000_7fff;
	localparam logic [31:0] CTRL_MASK = 32'h0103_0303;
	localparam logic [31:0] STATUS_MASK = 32'h0000_00ff;
	localparam logic [31:0] RATE_RST = 32'h0000_0000;
	localparam logic [31:0] TAG_RST = 32'h0000_0001; // vid 1, priority 0
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing: one pacing unit per byte is 20 ns
	// ----------------------------------------------------------------
	localparam int RATE_UNIT_NS = 20;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RATE_UNIT_CYC = (RATE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEPV_EGR_PASS = 2'b00, // normal frames untouched, special tags stripped
		SEPV_EGR_STRIP = 2'b01, // every tag stripped
		SEPV_EGR_HYBRID = 2'b10, // mixed tagging and retagging
		SEPV_EGR_SRC_TAG = 2'b11 // source-indicating special tag added
	} sepv_egress_type_t;

	typedef struct packed {
		logic [2:0] prio;
		logic [11:0] vid;
		sepv_egress_type_t egress_type;
	} sepv_port_tag_t;

	typedef struct packed {
		logic strip_normal;
		logic strip_special;
		logic retag;
		logic add_src_tag;
	} sepv_tag_action_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} sepv_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} sepv_apb_rsp_t;

endpackage : sepv_pkg

/* File: src/sepv_byte_pacer.sv */
// per-queue byte pacer: after each byte, holds off the next for (rate+1) units
// assumes i_byte_sent is a one-cycle pulse from the scheduler on the same clock
module sepv_byte_pacer #(
	parameter int RATE_W = 13,
	parameter int UNIT_CYC = 2
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_enable,
	input wire logic [RATE_W-1:0] i_rate,
	input wire logic i_byte_sent,
	output logic o_byte_ready
);

	localparam int CNT_W = RATE_W + $clog2(UNIT_CYC + 1) + 1;

	logic [CNT_W-1:0] cnt_reg; // cycles left before the next byte
	logic [CNT_W-1:0] load_val; // full gap for one byte

	// gap in cycles, less one because the loading cycle counts
	always_comb
	begin
		load_val = CNT_W'((CNT_W'(i_rate) + CNT_W'(1)) * CNT_W'(UNIT_CYC) - CNT_W'(1));
	end

	// ----------------------------------------------------------------
	// gap counter
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst || !i_enable)
		begin
			// pacing off: no gap, the queue may send freely
			cnt_reg <= '0;
			o_byte_ready <= 1'b1;
		end
		else if (i_byte_sent)
		begin
			cnt_reg <= load_val;
			o_byte_ready <= (load_val == '0);
		end
		else if (cnt_reg != '0)
		begin
			cnt_reg <= cnt_reg - CNT_W'(1);
			o_byte_ready <= (cnt_reg == CNT_W'(1));
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_gap_min;
		!o_byte_ready ##1 o_byte_ready;
	endsequence

	AST_PACE_MIN_GAP: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_enable && i_byte_sent && i_rate == '0 && UNIT_CYC == 2) ##1 (i_enable && !i_byte_sent)
		|-> s_gap_min)
		else $error("pacer gap for rate zero is not two cycles");

	AST_PACE_OFF: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!i_enable |=> o_byte_ready)
		else $error("pacer blocked while pacing disabled");

endmodule : sepv_byte_pacer

/* File: tb/sepv_regs_test.sv */
// self-checking bench of the egress pacing and default tag register bank
// assumes the sepv_pkg package is compiled first and the bank answers apb with one wait state
module sepv_regs_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// signals and bookkeeping
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] data;
		logic err;
	} sepv_exp_t; // one expected apb answer

	logic i_ref_clk; // 100 MHz clock
	logic i_srst; // synchronous reset, active high
	sepv_pkg::sepv_apb_req_t apb_req; // request driven by the bench
	sepv_pkg::sepv_apb_rsp_t apb_rsp; // answer of the bank
	logic [sepv_pkg::NUM_QUEUES-1:0] byte_sent; // scheduler pulses
	logic [sepv_pkg::NUM_QUEUES-1:0][sepv_pkg::RATE_W-1:0] queue_rate;
	logic [sepv_pkg::NUM_QUEUES-1:0] queue_ready;
	logic pace_enable;
	sepv_pkg::sepv_port_tag_t [sepv_pkg::NUM_PORTS-1:0] port_tag;
	sepv_pkg::sepv_tag_action_t [sepv_pkg::NUM_PORTS-1:0] port_action;
	sepv_exp_t exp_q[$]; // answers still owed by the bank
	int miscompares;
	int checked;

	sepv_regs #(.UNIT_CYC(2)) u_dut (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_apb(apb_req),
		.i_byte_sent(byte_sent),
		.o_apb(apb_rsp),
		.o_queue_rate(queue_rate),
		.o_queue_ready(queue_ready),
		.o_pace_enable(pace_enable),
		.o_port_tag(port_tag),
		.o_port_action(port_action)
	);

	// ----------------------------------------------------------------
	// clock and shared tasks
	// ----------------------------------------------------------------
	// free-running clock, 10 ns period
	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// one apb transfer; the answer is judged by the monitor below
	task automatic apb_xfer(input logic [15:0] addr, input logic wr, input logic [31:0] wdata,
		input logic [3:0] strb, input logic [31:0] exp_data, input logic exp_err);
		int n;
		@(posedge i_ref_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata, pstrb: strb};
		exp_q.push_back('{data: exp_data, err: exp_err});
		@(posedge i_ref_clk);
		apb_req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (apb_rsp.pready !== 1'b1 && n < 50);
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb_xfer

	// byte address of a register number
	function automatic logic [15:0] reg_addr(input logic [13:0] idx);
		return {idx, 2'b00};
	endfunction : reg_addr

	// ----------------------------------------------------------------
	// monitor: takes the oldest note whenever the bank answers
	// ----------------------------------------------------------------
	// a read answer carries data only in its pready cycle, so it is judged there
	always @(posedge i_ref_clk)
	begin
		if (apb_rsp.pready === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				miscompares++;
				$display("wrong value at %0t: answer without a request", $time);
			end
			else
			begin
				sepv_exp_t e;
				e = exp_q.pop_front();
				check(apb_rsp.prdata, e.data, "prdata");
				check({31'h0, apb_rsp.pslverr}, {31'h0, e.err}, "pslverr");
			end
		end
	end

	// ----------------------------------------------------------------
	// closing and watchdog
	// ----------------------------------------------------------------
	task automatic end_of_test;
		if (exp_q.size() != 0)
			miscompares++;
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// the tests need a few hundred cycles; this leaves wide margin
	initial
	begin
		#200000;
		miscompares++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [13:0] rate_idx [4];
		logic [31:0] w;
		logic [3:0] act;
		int r;
		int n;
		rate_idx = '{sepv_pkg::IDX_P1_Q01_RATE, sepv_pkg::IDX_P1_Q23_RATE,
			sepv_pkg::IDX_P2_Q01_RATE, sepv_pkg::IDX_P2_Q23_RATE};
		miscompares = 0;
		checked = 0;
		i_srst = 1'b1;
		apb_req = '0;
		byte_sent = '0;
		void'($urandom(26767));
		repeat (10) @(posedge i_ref_clk);
		i_srst <= 1'b0;

		// reset values of the pacing and tag registers and of the tag outputs
		for (int i = 0; i < 4; i++)
			apb_xfer(reg_addr(rate_idx[i]), 1'b0, 32'h0, 4'hf, sepv_pkg::RATE_RST, 1'b0);
		for (int p = 0; p < 3; p++)
		begin
			apb_xfer(reg_addr(sepv_pkg::IDX_P0_TAG + 14'(p)), 1'b0, 32'h0, 4'hf, sepv_pkg::TAG_RST, 1'b0);
			check({20'h0, port_tag[p].vid}, 32'h0000_0001, "reset vid");
			check({29'h0, port_tag[p].prio}, 32'h0, "reset prio");
		end
		$display("test reset values done");

		// pacing fields: random words, reserved bits must drop
		for (int i = 0; i < 4; i++)
		begin
			w = $urandom();
			apb_xfer(reg_addr(rate_idx[i]), 1'b1, w, 4'hf, 32'h0, 1'b0);
			apb_xfer(reg_addr(rate_idx[i]), 1'b0, 32'h0, 4'hf, w & sepv_pkg::RATE_MASK, 1'b0);
			check({19'h0, queue_rate[2*i]}, {19'h0, w[12:0]}, "low queue rate");
			check({19'h0, queue_rate[2*i+1]}, {19'h0, w[25:13]}, "high queue rate");
		end
		$display("test pacing fields done");

		// default tags: three separate registers, reserved bits dropped
		for (int p = 0; p < 3; p++)
		begin
			w = $urandom();
			apb_xfer(reg_addr(sepv_pkg::IDX_P0_TAG + 14'(p)), 1'b1, w, 4'hf, 32'h0, 1'b0);
			apb_xfer(reg_addr(sepv_pkg::IDX_P0_TAG + 14'(p)), 1'b0, 32'h0, 4'hf, w & sepv_pkg::TAG_MASK, 1'b0);
			check({20'h0, port_tag[p].vid}, {20'h0, w[11:0]}, "vid");
			check({29'h0, port_tag[p].prio}, {29'h0, w[14:12]}, "prio");
		end
		// a lane with its strobe low keeps the old byte
		apb_xfer(reg_addr(sepv_pkg::IDX_P1_TAG), 1'b1, 32'h0000_7123, 4'hf, 32'h0, 1'b0);
		apb_xfer(reg_addr(sepv_pkg::IDX_P1_TAG), 1'b1, 32'h0000_00ab, 4'h1, 32'h0, 1'b0);
		apb_xfer(reg_addr(sepv_pkg::IDX_P1_TAG), 1'b0, 32'h0, 4'hf, 32'h0000_71ab, 1'b0);
		$display("test default tags done");

		// every egress type on all three ports
		for (int t = 0; t < 4; t++)
		begin
			w = 32'(t) | (32'(t) << 8) | (32'(t) << 16);
			apb_xfer(reg_addr(sepv_pkg::IDX_EGRESS_CTRL), 1'b1, w | 32'hfcfc_fcfc, 4'hf, 32'h0, 1'b0);
			apb_xfer(reg_addr(sepv_pkg::IDX_EGRESS_CTRL), 1'b0, 32'h0, 4'hf, w, 1'b0);
			act = (t == 0) ? 4'b0100 : (t == 1) ? 4'b1100 : (t == 2) ? 4'b0010 : 4'b0001;
			for (int p = 0; p < 3; p++)
				check({28'h0, port_action[p]}, {28'h0, act}, "egress action");
		end
		$display("test egress types done");

		// unmapped, misaligned and read-only places
		apb_xfer(16'h7058, 1'b1, 32'hffff_ffff, 4'hf, 32'h0, 1'b1);
		apb_xfer(16'h7058, 1'b0, 32'h0, 4'hf, 32'h0, 1'b1);
		apb_xfer(16'h703d, 1'b0, 32'h0, 4'hf, 32'h0, 1'b1);
		apb_xfer(reg_addr(sepv_pkg::IDX_PACE_STATUS), 1'b1, 32'h0, 4'hf, 32'h0, 1'b0);
		apb_xfer(reg_addr(sepv_pkg::IDX_PACE_STATUS), 1'b0, 32'h0, 4'hf, 32'h0000_00ff, 1'b0);
		$display("test refused accesses done");

		// pacing: off by default, then (rate+1) x 20 ns per byte
		for (int k = 0; k < 3; k++)
		begin
			r = (k == 0) ? 0 : $urandom_range(1, 40);
			apb_xfer(reg_addr(sepv_pkg::IDX_P2_Q01_RATE), 1'b1, 32'(r) << 13, 4'hf, 32'h0, 1'b0);
			apb_xfer(reg_addr(sepv_pkg::IDX_EGRESS_CTRL), 1'b1, (k == 0) ? 32'h0 : 32'h0100_0000, 4'hf, 32'h0, 1'b0);
			repeat (2) @(posedge i_ref_clk);
			byte_sent <= 8'h20;
			@(posedge i_ref_clk);
			byte_sent <= 8'h00;
			n = 0;
			#1;
			while (queue_ready[5] === 1'b0 && n < 200)
			begin
				n++;
				@(posedge i_ref_clk);
				#1;
			end
			check(32'(n), (k == 0) ? 32'h0 : 32'(2 * (r + 1) - 1), "pacing gap");
			check({24'h0, queue_ready}, 32'h0000_00ff, "queue ready after gap");
		end
		$display("test pacing done");
		end_of_test();
	end
endmodule : sepv_regs_test
